// ===== samr_pkg.sv
// Package for the serial converter readout block: constants, types, behaviour list
// Behaviour
// - Start bit and address bits enter a five-bit shift register under chip select.
// - Two-input single-ended: odd bit 0 selects input 0, 1 selects input 1.
// - Two-input differential: odd bit 0 makes input 0 positive, 1 reverses.
// - Two-input variant ties lower pair low, upper pair high, common to ground.
// - Four-input single-ended: odd,upper 00->0, 01->2, 10->1, 11->3.
// - Four-input differential: upper selects pair, odd bit picks positive side.
// - Four-input variant holds lower pair high, common to ground; three address bits.
// - Eight-input single-ended: input equals twice pair field plus odd bit, against common.
// - Eight-input differential: pair field picks pair, odd bit picks positive side.
// - Single-input variant has no data-in and needs no address.
// - Each result bit appears on data-out after the falling serial clock edge.
// - Converter samples data-in on rising serial clock edge.
// - Converter makes an eight-bit successive-approximation result and sends it serially.
package samr_pkg;
    localparam int SAMR_RES_BITS = 8;
    localparam int SAMR_SR_BITS = 5;
    localparam int SAMR_INPUTS = 8;
    localparam logic [3:0] SAMR_INPUTS_W = 4'h8;
    localparam logic [2:0] SAMR_SAR_TOP = 3'h7;
    localparam logic [3:0] SAMR_RES_CNT = 4'h8;
    localparam logic [SAMR_RES_BITS-1:0] SAMR_RESULT_RST = 8'h00;

    typedef enum logic [1:0] {
        SAMR_VAR_ONE,
        SAMR_VAR_TWO,
        SAMR_VAR_FOUR,
        SAMR_VAR_EIGHT
    } samr_variant_e;

    typedef enum logic [2:0] {
        SAMR_ST_IDLE,
        SAMR_ST_ADDR,
        SAMR_ST_SETTLE,
        SAMR_ST_CONV,
        SAMR_ST_DONE
    } samr_state_e;

    // Multiplexer choice handed to the analog front end
    typedef struct packed {
        logic single_or_differential_bit;
        logic odd_bit;
        logic [1:0] pair_field;
    } samr_addr_s;

    typedef struct packed {
        logic [SAMR_INPUTS-1:0] pos_sel;
        logic [SAMR_INPUTS-1:0] neg_sel;
        logic common_return_input;
        logic analog_ground;
    } samr_mux_s;
endpackage : samr_pkg

// ===== samr_mux_decode.sv
// Multiplexer address decode into positive and negative input selections
`timescale 1ns/100ps
`default_nettype none
module samr_mux_decode
(
    input wire samr_pkg::samr_variant_e i_variant,
    input wire samr_pkg::samr_addr_s i_addr,
    output samr_pkg::samr_mux_s o_mux
);
    logic [1:0] pair;
    logic [2:0] even_in;

    always_comb
    begin
        pair = i_addr.pair_field;
        o_mux = '0;
        unique case (i_variant)
            samr_pkg::SAMR_VAR_ONE:
            begin
                o_mux.pos_sel[0] = 1'b1;
                o_mux.analog_ground = 1'b1;
            end
            samr_pkg::SAMR_VAR_TWO:
            begin
                pair = 2'h2;
            end
            samr_pkg::SAMR_VAR_FOUR:
            begin
                pair = {i_addr.pair_field[1], 1'b1};
            end
            samr_pkg::SAMR_VAR_EIGHT:
            begin
                pair = i_addr.pair_field;
            end
        endcase
        // Lower pair bit only moves the pair in the eight-input part
        even_in = (i_variant == samr_pkg::SAMR_VAR_EIGHT) ? {pair, 1'b0} :
                  (i_variant == samr_pkg::SAMR_VAR_FOUR) ? {1'b0, pair[1], 1'b0} : 3'h0;
        if (i_variant != samr_pkg::SAMR_VAR_ONE)
        begin
            if (i_addr.single_or_differential_bit)
            begin
                o_mux.pos_sel[even_in | {2'h0, i_addr.odd_bit}] = 1'b1;
                if (i_variant == samr_pkg::SAMR_VAR_EIGHT)
                    o_mux.common_return_input = 1'b1;
                else
                    o_mux.analog_ground = 1'b1;
            end
            else
            begin
                o_mux.pos_sel[even_in | {2'h0, i_addr.odd_bit}] = 1'b1;
                o_mux.neg_sel[even_in | {2'h0, ~i_addr.odd_bit}] = 1'b1;
            end
        end
    end
endmodule : samr_mux_decode
`default_nettype wire

// ===== samr_top.sv
// Converter-side serial control: address shift-in, SAR conversion, serial result out
`timescale 1ns/100ps
`default_nettype none
module samr_top
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire samr_pkg::samr_variant_e i_variant,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_serial_data_in,
    input wire logic i_comparator,
    output logic o_serial_data_out,
    output logic o_serial_data_out_oe,
    output logic [samr_pkg::SAMR_RES_BITS-1:0] o_dac_code,
    output samr_pkg::samr_mux_s o_mux,
    output logic [samr_pkg::SAMR_RES_BITS-1:0] o_result,
    output logic o_busy
);
    typedef struct packed {
        logic [1:0] cs_sync;
        logic [1:0] sclk_sync;
        logic [1:0] din_sync;
        logic sclk_prev;
        samr_pkg::samr_state_e state;
        logic [samr_pkg::SAMR_SR_BITS-1:0] shift;
        logic [2:0] addr_left;
        samr_pkg::samr_addr_s addr;
        logic [2:0] sar_bit;
        logic [samr_pkg::SAMR_RES_BITS-1:0] trial;
        logic [samr_pkg::SAMR_RES_BITS-1:0] result;
        logic [3:0] out_left;
        logic dout;
        logic dout_oe;
    } samr_reg_s;

    samr_reg_s r;
    samr_reg_s next_r;
    logic cs_act;
    logic sclk_rise;
    logic sclk_fall;
    logic [2:0] addr_len;
    samr_pkg::samr_addr_s sr_addr;

    samr_mux_decode u_decode
    (
        .i_variant(i_variant),
        .i_addr(r.addr),
        .o_mux(o_mux)
    );

    always_comb
    begin
        cs_act = ~r.cs_sync[1];
        sclk_rise = r.sclk_sync[1] & ~r.sclk_prev;
        sclk_fall = ~r.sclk_sync[1] & r.sclk_prev;
        // Address bits after the start bit, by variant
        unique case (i_variant)
            samr_pkg::SAMR_VAR_ONE: addr_len = 3'h0;
            samr_pkg::SAMR_VAR_TWO: addr_len = 3'h2;
            samr_pkg::SAMR_VAR_FOUR: addr_len = 3'h3;
            samr_pkg::SAMR_VAR_EIGHT: addr_len = 3'h4;
        endcase
        sr_addr = '0;
        next_r = r;
        next_r.cs_sync = {r.cs_sync[0], i_cs_n};
        next_r.sclk_sync = {r.sclk_sync[0], i_sclk};
        next_r.din_sync = {r.din_sync[0], i_serial_data_in};
        next_r.sclk_prev = r.sclk_sync[1];
        if (!cs_act)
        begin
            // Deselect aborts and floats the data-out line
            next_r.state = samr_pkg::SAMR_ST_IDLE;
            next_r.dout_oe = 1'b0;
            next_r.dout = 1'b0;
        end
        else
        begin
            unique case (r.state)
                samr_pkg::SAMR_ST_IDLE:
                begin
                    next_r.shift = '0;
                    if (i_variant == samr_pkg::SAMR_VAR_ONE)
                        next_r.state = samr_pkg::SAMR_ST_SETTLE;
                    else if (sclk_rise && r.din_sync[1])
                    begin
                        next_r.shift = {{(samr_pkg::SAMR_SR_BITS-1){1'b0}}, 1'b1};
                        next_r.addr_left = addr_len;
                        next_r.state = samr_pkg::SAMR_ST_ADDR;
                    end
                end
                samr_pkg::SAMR_ST_ADDR:
                begin
                    if (sclk_rise)
                    begin
                        next_r.shift = {r.shift[samr_pkg::SAMR_SR_BITS-2:0], r.din_sync[1]};
                        next_r.addr_left = r.addr_left - 3'h1;
                        if (r.addr_left == 3'h1)
                        begin
                            unique case (i_variant)
                                samr_pkg::SAMR_VAR_TWO:
                                    sr_addr = {r.shift[0], r.din_sync[1], 2'h0};
                                samr_pkg::SAMR_VAR_FOUR:
                                    sr_addr = {r.shift[1:0], r.din_sync[1], 1'b0};
                                default:
                                    sr_addr = {r.shift[2:0], r.din_sync[1]};
                            endcase
                            next_r.addr = sr_addr;
                            next_r.state = samr_pkg::SAMR_ST_SETTLE;
                        end
                    end
                end
                samr_pkg::SAMR_ST_SETTLE:
                begin
                    // One falling edge lets the mux settle before conversion
                    if (sclk_fall)
                    begin
                        next_r.dout_oe = 1'b1;
                        next_r.dout = 1'b0;
                        next_r.sar_bit = samr_pkg::SAMR_SAR_TOP;
                        next_r.trial = {1'b1, {(samr_pkg::SAMR_RES_BITS-1){1'b0}}};
                        next_r.state = samr_pkg::SAMR_ST_CONV;
                    end
                end
                samr_pkg::SAMR_ST_CONV:
                begin
                    // Binary search; comparator high keeps the trial bit
                    next_r.trial[r.sar_bit] = i_comparator;
                    if (r.sar_bit == 3'h0)
                    begin
                        next_r.result = {r.trial[7:1], i_comparator};
                        next_r.out_left = samr_pkg::SAMR_RES_CNT;
                        next_r.state = samr_pkg::SAMR_ST_DONE;
                    end
                    else
                    begin
                        next_r.trial[r.sar_bit - 3'h1] = 1'b1;
                        next_r.sar_bit = r.sar_bit - 3'h1;
                    end
                end
                samr_pkg::SAMR_ST_DONE:
                begin
                    // Conversion needs 8 fast clocks, far under one serial bit time
                    if (sclk_fall && r.out_left != 4'h0)
                    begin
                        next_r.dout = r.result[r.out_left[2:0] - 3'h1];
                        next_r.out_left = r.out_left - 4'h1;
                    end
                end
                default:
                    next_r.state = samr_pkg::SAMR_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            r <= '0;
            r.cs_sync <= 2'h3;
            r.state <= samr_pkg::SAMR_ST_IDLE;
            r.result <= samr_pkg::SAMR_RESULT_RST;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign o_serial_data_out = r.dout;
    assign o_serial_data_out_oe = r.dout_oe;
    assign o_dac_code = r.trial;
    assign o_result = r.result;
    assign o_busy = (r.state != samr_pkg::SAMR_ST_IDLE);
endmodule : samr_top
`default_nettype wire

// ===== samr_top_assertions.sv
// Port checker for the converter readout block
`timescale 1ns/100ps
`default_nettype none
module samr_chk
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire samr_pkg::samr_variant_e i_variant,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic o_serial_data_out,
    input wire logic o_serial_data_out_oe,
    input wire samr_pkg::samr_mux_s o_mux,
    input wire logic [7:0] o_result,
    input wire logic o_busy
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    logic [3:0] age;
    logic sclk_q;
    // Clocks since the serial clock pin last fell
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sclk_q <= 1'b0;
            age <= 4'hF;
        end
        else
        begin
            sclk_q <= i_sclk;
            age <= (sclk_q && !i_sclk) ? 4'h0 : ((age == 4'hF) ? age : age + 4'h1);
        end
    end
    a_oe_cs_abort: assert property (i_cs_n [*4] |-> !o_serial_data_out_oe)
        else $error("data-out still driven with chip select high");
    a_idle_not_busy: assert property (i_cs_n [*5] |=> !o_busy)
        else $error("busy without chip select");
    a_oe_in_busy: assert property (o_serial_data_out_oe |-> o_busy)
        else $error("data-out driven while idle");
    a_bit_after_fall: assert property ($changed(o_serial_data_out) && o_serial_data_out_oe
        && $past(o_serial_data_out_oe) |-> age < 4'h7)
        else $error("result bit changed away from a falling serial clock");
    a_pos_neg_apart: assert property ((o_mux.pos_sel & o_mux.neg_sel) == 8'h00)
        else $error("input selected on both sides");
    a_two_range: assert property (i_variant == samr_pkg::SAMR_VAR_TWO
        |-> (o_mux.pos_sel | o_mux.neg_sel) < 8'h04)
        else $error("two-input variant selects a missing input");
    a_four_range: assert property (i_variant == samr_pkg::SAMR_VAR_FOUR
        |-> (o_mux.pos_sel | o_mux.neg_sel) < 8'h10)
        else $error("four-input variant selects a missing input");
    a_result_hold: assert property (!o_busy && $past(!o_busy) |-> $stable(o_result))
        else $error("result changed while idle");
endmodule : samr_chk
bind samr_top samr_chk i_samr_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_variant(i_variant),
    .i_cs_n(i_cs_n), .i_sclk(i_sclk), .o_serial_data_out(o_serial_data_out),
    .o_serial_data_out_oe(o_serial_data_out_oe), .o_mux(o_mux), .o_result(o_result),
    .o_busy(o_busy));
`default_nettype wire

// ===== samr_host_model.sv
// Host controller model: framing, address shift-in, serial readout
`timescale 1ns/100ps
`default_nettype none
module samr_host_model
(
    input wire logic i_dout,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_din,
    output logic [7:0] o_rx,
    output logic o_rx_valid
);
    logic lclk;
    initial
    begin
        lclk = 1'b0;
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_din = 1'b0;
        o_rx = 8'h00;
        o_rx_valid = 1'b0;
        #3;
        forever #40 lclk = ~lclk;
    end
    // Data set a full step before the rise; sample just before it
    task automatic pulse(input logic d, output logic s);
        @(posedge lclk) o_din <= d;
        @(posedge lclk)
        begin
            s = i_dout;
            o_sclk <= 1'b1;
        end
        @(posedge lclk) o_sclk <= 1'b0;
    endtask : pulse
    task automatic xfer(input int nb, input logic [3:0] a, input int lead, input int stop);
        logic s;
        logic [7:0] r;
        r = 8'h00;
        @(posedge lclk) o_cs_n <= 1'b0;
        // Zero clocks ahead of the start bit must be ignored; no start bit without address
        if (nb > 0) repeat (lead) pulse(1'b0, s);
        if (nb > 0) pulse(1'b1, s);
        for (int k = 0; k < nb; k++) pulse(a[3-k], s);
        // Last address fall settles the mux; with no address an initial clock does it
        if (nb == 0) pulse(~o_din, s);
        for (int i = 0; i < 9 && i != stop; i++)
        begin
            if (i < 8) pulse(~o_din, s);
            else
            begin
                repeat (2) @(posedge lclk);
                s = i_dout;
            end
            if (i > 0) r = {r[6:0], s};
        end
        @(posedge lclk) o_cs_n <= 1'b1;
        if (stop > 8)
        begin
            o_rx <= r;
            o_rx_valid <= 1'b1;
            @(posedge lclk) o_rx_valid <= 1'b0;
        end
    endtask : xfer
endmodule : samr_host_model
`default_nettype wire

// ===== samr_top_tb.sv
// Self-checking bench for the converter readout block
`timescale 1ns/100ps
`default_nettype none
module samr_top_tb;
    logic i_clk, i_rstn, cs_n, sclk, din, dout, oe, busy, rxv;
    logic [7:0] ain, dac, res, rx;
    logic [26:0] e;
    logic [26:0] q[$];
    localparam realtime SAMR_ONE_SPAN_NS = 181000.0;
    samr_pkg::samr_variant_e vsel;
    samr_pkg::samr_mux_s mux;
    int n_mismatch = 0;
    int cmp_count = 0;
    integer seed = 32'h17C4;
    wire logic cmp = ain >= dac;
    // Undriven data line reads high, so a bit taken while released shows up
    wire logic dline = oe ? dout : 1'b1;
    initial
    begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    samr_top i_samr_top (.i_clk(i_clk), .i_rstn(i_rstn), .i_variant(vsel), .i_cs_n(cs_n),
        .i_sclk(sclk), .i_serial_data_in(din), .i_comparator(cmp), .o_serial_data_out(dout),
        .o_serial_data_out_oe(oe), .o_dac_code(dac), .o_mux(mux), .o_result(res),
        .o_busy(busy));
    samr_host_model i_samr_host_model (.i_dout(dline), .o_cs_n(cs_n), .o_sclk(sclk),
        .o_din(din), .o_rx(rx), .o_rx_valid(rxv));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report
    task automatic run(input samr_pkg::samr_variant_e v, input logic [3:0] a, input int stop);
        logic [7:0] x;
        logic [1:0] ps;
        realtime t0;
        x = 8'($random(seed));
        ps = (v == samr_pkg::SAMR_VAR_EIGHT) ? a[1:0] : {1'b0, v == samr_pkg::SAMR_VAR_FOUR && a[1]};
        @(posedge i_clk)
        begin
            vsel <= v;
            ain <= x;
        end
        if (stop > 8) q.push_back({v != samr_pkg::SAMR_VAR_ONE, x, 8'h01 << {ps, a[2]},
            a[3] ? 8'h00 : 8'h01 << {ps, ~a[2]},
            v == samr_pkg::SAMR_VAR_EIGHT && a[3],
            v == samr_pkg::SAMR_VAR_ONE || (v != samr_pkg::SAMR_VAR_EIGHT && a[3])});
        t0 = $realtime;
        i_samr_host_model.xfer((v == samr_pkg::SAMR_VAR_ONE) ? 0 : int'(v) + 1, a, x[0], stop);
        if (v == samr_pkg::SAMR_VAR_ONE && stop > 8)
            chk("single readout time", {7'h00, ($realtime - t0) <= SAMR_ONE_SPAN_NS}, 8'h01);
    endtask : run
    always @(posedge rxv)
    begin
        e = q.pop_front();
        chk("serial result", rx, e[25:18]);
        chk("result port", res, e[25:18]);
        chk("return select", {6'h00, mux.common_return_input, mux.analog_ground}, {6'h00, e[1:0]});
        if (e[26])
        begin
            chk("positive select", mux.pos_sel, e[17:10]);
            chk("negative select", mux.neg_sel, e[9:2]);
        end
    end
    initial
    begin
        i_rstn = 1'b0;
        vsel = samr_pkg::SAMR_VAR_EIGHT;
        ain = 8'h00;
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        for (int v = 1; v < 4; v++)
        begin
            for (int a = 0; a < 16; a++) run(samr_pkg::samr_variant_e'(v), a[3:0], 99);
            $display("variant %0d addressing done", v);
        end
        repeat (2) run(samr_pkg::SAMR_VAR_ONE, 4'h0, 99);
        $display("single-input readout done");
        run(samr_pkg::SAMR_VAR_EIGHT, 4'hD, 3);
        repeat (8) @(posedge i_clk);
        chk("abort drive", {7'h00, oe}, 8'h00);
        chk("abort busy", {7'h00, busy}, 8'h00);
        $display("abort done");
        final_report();
    end
    initial
    begin
        #400000;
        n_mismatch++;
        final_report();
    end
endmodule : samr_top_tb
`default_nettype wire
